// file: core/cslc_pkg.sv
// Constants, types and register map of the clock source lock and status control block.
// Functional notes
// - Lock bit freezes main control, and calibration while fast osc drives main
// - Once locked, lock register ignores all access
// - Lock bit reset value comes from fuse
// - Bit 7 shows external clock started
// - Stable flags only while source requested
// - Run-in-standby alone leaves stable flag zero
// - Bit 0 high while main source switches
// - Internal run-in-standby keeps oscillator always running
// - Internal oscillator gated off unless requested
// - Gate opens four cycles after request and synchronised ready
// - Frequency trim resets from fuse-selected table
// - Calibration lock from fuse blocks calibration writes
// - Temperature slope resets from fuse-selected table
// - Crystal select/startup locked while enabled or stable
// - Startup code selects 1k/16k/32k/64k cycles
// - External clock source waits two edges instead of the startup count
// - Select bit: crystal zero, external clock one
// - Enabled crystal runs always with standby, else on request
// - Crystal output follows request in two cycles
// - Enable overrides pins, freezes select and startup
// - Crystal enable and standby are protected
// - Protected writes need open key window
package cslc_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_MAIN_LOCK = 8'h02;
  localparam logic [7:0] IDX_MAIN_STATUS = 8'h03;
  localparam logic [7:0] IDX_FAST_CTRL = 8'h10;
  localparam logic [7:0] IDX_FREQ_CAL = 8'h11;
  localparam logic [7:0] IDX_TEMP_CAL = 8'h12;
  localparam logic [7:0] IDX_SLOW_CTRL = 8'h18;
  localparam logic [7:0] IDX_XTAL_CTRL = 8'h1C;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions.
  localparam int STS_EXT_BIT = 7;
  localparam int STS_XTAL_BIT = 6;
  localparam int STS_SLOW_BIT = 5;
  localparam int STS_FAST_BIT = 4;
  localparam int STS_SWITCH_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam int RUN_IN_STANDBY_BIT = 1;
  localparam int XTAL_EN_BIT = 0;
  localparam int XTAL_SEL_BIT = 2;
  localparam int CRYSTAL_STARTUP_COUNT_LSB = 4;
  localparam int CRYSTAL_STARTUP_COUNT_MSB = 5;
  localparam int CAL_LOCK_BIT = 7;
  localparam int FREQ_W = 7;
  localparam int TEMP_W = 4;

  // Main clock source codes.
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;

  // Crystal start-up codes.
  localparam logic [1:0] CRYSTAL_STARTUP_COUNT_1K = 2'h0;
  localparam logic [1:0] CRYSTAL_STARTUP_COUNT_16K = 2'h1;
  localparam logic [1:0] CRYSTAL_STARTUP_COUNT_32K = 2'h2;

  // Timing: internal gates in pclk cycles, crystal and external clock in their own edges.
  localparam logic [2:0] GATE_INT_CYC = 3'h4;
  localparam logic [2:0] GATE_XTAL_CYC = 3'h2;
  localparam logic [2:0] EXT_START_CYC = 3'h2;
  localparam int XTAL_CNT_W = 17;

  // One bit per clock source, indexed by source code.
  typedef struct packed {
    logic ext;
    logic xtal;
    logic slow;
    logic fast;
  } cslc_src_t;

  // Crystal oscillator sequencing states.
  typedef enum logic [2:0] {
    XS_OFF = 3'b001,
    XS_START = 3'b010,
    XS_RUN = 3'b100
  } cslc_xstate_t;

endpackage

// file: core/cslc_top.sv
// Clock source lock, oscillator gating, calibration and status registers behind APB.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module cslc_top #(
  parameter int XTAL_SUT_1K = 1024, // Crystal start-up for code 0.
  parameter int XTAL_SUT_16K = 16384, // Crystal start-up for code 1.
  parameter int XTAL_SUT_32K = 32768, // Crystal start-up for code 2.
  parameter int XTAL_SUT_64K = 65536, // Crystal start-up for code 3.
  parameter logic [6:0] FREQ_CAL_16M = 7'h40, // Factory trim, 16 MHz fuse setting.
  parameter logic [6:0] FREQ_CAL_20M = 7'h40, // Factory trim, 20 MHz fuse setting.
  parameter logic [3:0] TEMP_CAL_16M = 4'h8, // Factory slope, 16 MHz fuse setting.
  parameter logic [3:0] TEMP_CAL_20M = 4'h8 // Factory slope, 20 MHz fuse setting.
) (
  input wire logic pclk, // APB clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [9:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic protect_open, // Protected-write key window is open.
  input wire logic fuse_osc_lock_bit, // Oscillator lock fuse.
  input wire logic fuse_freq_select, // Frequency select fuse, 1 for 20 MHz.
  input wire logic [1:0] main_clock_select, // Source chosen by main selector.
  input wire cslc_pkg::cslc_src_t periph_req, // Peripheral clock requests.
  input wire logic fast_osc_ready, // Fast oscillator analog ready, async.
  input wire logic slow_osc_ready, // Slow oscillator analog ready, async.
  input wire logic crystal_pin_one_clk, // Crystal oscillator output, async.
  input wire logic external_clock_input, // External clock pin, async.
  output cslc_pkg::cslc_src_t osc_enable, // Analog run enables.
  output cslc_pkg::cslc_src_t osc_gate, // Output gates open toward consumers.
  output logic [6:0] freq_trim_field, // Frequency trim to fast oscillator.
  output logic [3:0] temp_slope_trim, // Temperature slope to fast oscillator.
  output logic crystal_pin_override, // Crystal pins taken for oscillator.
  output logic crystal_source_ext, // Crystal block uses external clock.
  output logic [1:0] main_clock_active, // Source now driving the main clock.
  output logic main_ctrl_locked // Main clock control registers frozen.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  localparam int NSYNC = 4;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic fast_rdy_s;
  logic slow_rdy_s;
  logic xtal_edge;
  logic ext_edge;

  // Asynchronous inputs gathered for one synchroniser loop.
  assign async_in = {external_clock_input, crystal_pin_one_clk, slow_osc_ready, fast_osc_ready};

  // Each input passes two flip-flops; a third stage feeds edge detection.
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_r[g] <= 1'b0;
        sync2_r[g] <= 1'b0;
        sync3_r[g] <= 1'b0;
      end else begin
        sync1_r[g] <= async_in[g];
        sync2_r[g] <= sync1_r[g];
        sync3_r[g] <= sync2_r[g];
      end
    end
  end

  // Levels and rising edges seen by the block's logic.
  assign fast_rdy_s = sync2_r[0];
  assign slow_rdy_s = sync2_r[1];
  assign xtal_edge = sync2_r[2] & ~sync3_r[2];
  assign ext_edge = sync2_r[3] & ~sync3_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic [7:0] reg_idx;
  logic aligned;
  logic hit_lock;
  logic hit_status;
  logic hit_fast;
  logic hit_freq;
  logic hit_temp;
  logic hit_slow;
  logic hit_xtal;
  logic mapped;
  logic wr_acc;
  logic wr_prot;
  logic [7:0] wbyte;

  // Register index from the word address; offsets are word aligned.
  assign reg_idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit_lock = aligned && (reg_idx == cslc_pkg::IDX_MAIN_LOCK);
  assign hit_status = aligned && (reg_idx == cslc_pkg::IDX_MAIN_STATUS);
  assign hit_fast = aligned && (reg_idx == cslc_pkg::IDX_FAST_CTRL);
  assign hit_freq = aligned && (reg_idx == cslc_pkg::IDX_FREQ_CAL);
  assign hit_temp = aligned && (reg_idx == cslc_pkg::IDX_TEMP_CAL);
  assign hit_slow = aligned && (reg_idx == cslc_pkg::IDX_SLOW_CTRL);
  assign hit_xtal = aligned && (reg_idx == cslc_pkg::IDX_XTAL_CTRL);
  assign mapped = hit_lock | hit_status | hit_fast | hit_freq | hit_temp | hit_slow | hit_xtal;
  assign wr_acc = psel & penable & pwrite;
  assign wr_prot = wr_acc & protect_open;
  assign wbyte = pwdata[7:0];

  // Zero-wait slave; unmapped addresses end with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.

  logic loaded_r;
  logic main_lock_r;
  logic cal_lock_r;
  logic [6:0] freq_cal_r;
  logic [3:0] temp_cal_r;
  logic fast_stdby_r;
  logic slow_stdby_r;
  logic xtal_en_r;
  logic xtal_stdby_r;
  logic xtal_sel_r;
  logic [1:0] crystal_startup_count_r;
  logic [1:0] active_src_r;
  logic [1:0] active_src_nxt;
  logic switching;
  logic cal_frozen;
  logic xtal_cfg_frozen;
  logic stable_xtal;
  cslc_pkg::cslc_src_t stable;
  cslc_pkg::cslc_src_t main_req;
  cslc_pkg::cslc_src_t req;

  // Calibration frozen by fuse lock or main lock while fast osc drives main.
  assign cal_frozen = cal_lock_r | (main_lock_r && active_src_r == cslc_pkg::SRC_FAST);
  // Select and start-up fields frozen while enabled or stable.
  assign xtal_cfg_frozen = xtal_en_r | stable_xtal;

  // Fuse-driven values loaded at the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= 1'b0;
      main_lock_r <= 1'b0;
      cal_lock_r <= 1'b0;
      freq_cal_r <= 7'h00;
      temp_cal_r <= 4'h0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      main_lock_r <= fuse_osc_lock_bit;
      cal_lock_r <= fuse_osc_lock_bit;
      freq_cal_r <= fuse_freq_select ? FREQ_CAL_20M : FREQ_CAL_16M;
      temp_cal_r <= fuse_freq_select ? TEMP_CAL_20M : TEMP_CAL_16M;
    end else begin
      if (wr_prot && hit_lock && !main_lock_r) begin
        main_lock_r <= wbyte[cslc_pkg::LOCK_BIT];
      end
      if (wr_prot && hit_freq && !cal_frozen) begin
        freq_cal_r <= wbyte[cslc_pkg::FREQ_W-1:0];
      end
      if (wr_prot && hit_temp && !cal_frozen) begin
        temp_cal_r <= wbyte[cslc_pkg::TEMP_W-1:0];
      end
    end
  end

  // Oscillator control registers, all behind the protection key.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_stdby_r <= cslc_pkg::RST_BYTE[cslc_pkg::RUN_IN_STANDBY_BIT];
      slow_stdby_r <= cslc_pkg::RST_BYTE[cslc_pkg::RUN_IN_STANDBY_BIT];
      xtal_en_r <= cslc_pkg::RST_BYTE[cslc_pkg::XTAL_EN_BIT];
      xtal_stdby_r <= cslc_pkg::RST_BYTE[cslc_pkg::RUN_IN_STANDBY_BIT];
      xtal_sel_r <= cslc_pkg::RST_BYTE[cslc_pkg::XTAL_SEL_BIT];
      crystal_startup_count_r <= cslc_pkg::RST_BYTE[cslc_pkg::CRYSTAL_STARTUP_COUNT_MSB:cslc_pkg::CRYSTAL_STARTUP_COUNT_LSB];
    end else begin
      if (wr_prot && hit_fast) begin
        fast_stdby_r <= wbyte[cslc_pkg::RUN_IN_STANDBY_BIT];
      end
      if (wr_prot && hit_slow) begin
        slow_stdby_r <= wbyte[cslc_pkg::RUN_IN_STANDBY_BIT];
      end
      if (wr_prot && hit_xtal) begin
        xtal_en_r <= wbyte[cslc_pkg::XTAL_EN_BIT];
        xtal_stdby_r <= wbyte[cslc_pkg::RUN_IN_STANDBY_BIT];
        if (!xtal_cfg_frozen) begin
          xtal_sel_r <= wbyte[cslc_pkg::XTAL_SEL_BIT];
          crystal_startup_count_r <= wbyte[cslc_pkg::CRYSTAL_STARTUP_COUNT_MSB:cslc_pkg::CRYSTAL_STARTUP_COUNT_LSB];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main clock source switching.

  // Both the old and the new source stay requested during a switch.
  assign switching = (main_clock_select != active_src_r);
  assign main_req = cslc_pkg::cslc_src_t'((4'h1 << main_clock_select) | (4'h1 << active_src_r));
  assign req = periph_req | main_req;
  // Change over only once the newly selected source reports stable.
  assign active_src_nxt = (switching && stable[main_clock_select]) ? main_clock_select
                                                                   : active_src_r;

  // Active source register; the main clock starts on the fast oscillator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_src_r <= cslc_pkg::SRC_FAST;
    end else begin
      active_src_r <= active_src_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillators: request gating and clock-gate delay.

  logic [2:0] fast_gate_cnt_r;
  logic [2:0] slow_gate_cnt_r;
  logic fast_run;
  logic slow_run;

  // Run when requested or forced by run-in-standby.
  assign fast_run = req.fast | fast_stdby_r;
  assign slow_run = req.slow | slow_stdby_r;

  // Gate count starts once analog ready and requested; standby leaves ready high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_gate_cnt_r <= 3'h0;
      slow_gate_cnt_r <= 3'h0;
    end else begin
      if (!(req.fast && fast_rdy_s)) begin
        fast_gate_cnt_r <= 3'h0;
      end else if (fast_gate_cnt_r != cslc_pkg::GATE_INT_CYC) begin
        fast_gate_cnt_r <= fast_gate_cnt_r + 3'h1;
      end
      if (!(req.slow && slow_rdy_s)) begin
        slow_gate_cnt_r <= 3'h0;
      end else if (slow_gate_cnt_r != cslc_pkg::GATE_INT_CYC) begin
        slow_gate_cnt_r <= slow_gate_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal oscillator: start-up sequence and output gate.

  cslc_pkg::cslc_xstate_t xstate_r;
  cslc_pkg::cslc_xstate_t xstate_nxt;
  logic [cslc_pkg::XTAL_CNT_W-1:0] xcnt_r;
  logic [cslc_pkg::XTAL_CNT_W-1:0] xcnt_target;
  logic [2:0] xgate_cnt_r;
  logic xtal_run;

  // Runs when enabled and either forced on or requested.
  assign xtal_run = xtal_en_r & (xtal_stdby_r | req.xtal);
  // Start-up length; an external clock on the pin needs only EXT_START_CYC edges.
  assign xcnt_target = xtal_sel_r ? cslc_pkg::XTAL_CNT_W'(cslc_pkg::EXT_START_CYC) :
                       (crystal_startup_count_r == cslc_pkg::CRYSTAL_STARTUP_COUNT_1K) ? cslc_pkg::XTAL_CNT_W'(XTAL_SUT_1K) :
                       (crystal_startup_count_r == cslc_pkg::CRYSTAL_STARTUP_COUNT_16K) ? cslc_pkg::XTAL_CNT_W'(XTAL_SUT_16K) :
                       (crystal_startup_count_r == cslc_pkg::CRYSTAL_STARTUP_COUNT_32K) ? cslc_pkg::XTAL_CNT_W'(XTAL_SUT_32K) :
                       cslc_pkg::XTAL_CNT_W'(XTAL_SUT_64K);

  // Sequencer next state.
  always_comb begin
    xstate_nxt = xstate_r;
    case (xstate_r)
      cslc_pkg::XS_OFF: begin
        if (xtal_run) begin
          xstate_nxt = cslc_pkg::XS_START;
        end
      end
      cslc_pkg::XS_START: begin
        if (!xtal_run) begin
          xstate_nxt = cslc_pkg::XS_OFF;
        end else if (xcnt_r >= xcnt_target) begin
          xstate_nxt = cslc_pkg::XS_RUN;
        end
      end
      cslc_pkg::XS_RUN: begin
        if (!xtal_run) begin
          xstate_nxt = cslc_pkg::XS_OFF;
        end
      end
      default: begin
        xstate_nxt = cslc_pkg::XS_OFF;
      end
    endcase
  end

  // State, start-up count and gate count in crystal edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xstate_r <= cslc_pkg::XS_OFF;
      xcnt_r <= '0;
      xgate_cnt_r <= 3'h0;
    end else begin
      xstate_r <= xstate_nxt;
      if (xstate_r != cslc_pkg::XS_START) begin
        xcnt_r <= '0;
      end else if (xtal_edge) begin
        xcnt_r <= xcnt_r + cslc_pkg::XTAL_CNT_W'(1);
      end
      if (!(req.xtal && xstate_r == cslc_pkg::XS_RUN)) begin
        xgate_cnt_r <= 3'h0;
      end else if (xtal_edge && xgate_cnt_r != cslc_pkg::GATE_XTAL_CYC) begin
        xgate_cnt_r <= xgate_cnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External clock start detection.

  logic [2:0] ext_cnt_r;

  // Counts pin edges while requested; two edges mean started.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_r <= 3'h0;
    end else if (!req.ext) begin
      ext_cnt_r <= 3'h0;
    end else if (ext_edge && ext_cnt_r != cslc_pkg::EXT_START_CYC) begin
      ext_cnt_r <= ext_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stability, gating and status.

  logic [7:0] status;
  logic [7:0] rd_byte;

  // Stable only while requested; standby alone never sets a flag.
  assign stable.fast = req.fast && fast_gate_cnt_r == cslc_pkg::GATE_INT_CYC;
  assign stable.slow = req.slow && slow_gate_cnt_r == cslc_pkg::GATE_INT_CYC;
  assign stable_xtal = req.xtal && xgate_cnt_r == cslc_pkg::GATE_XTAL_CYC;
  assign stable.xtal = stable_xtal;
  assign stable.ext = req.ext && ext_cnt_r == cslc_pkg::EXT_START_CYC;

  // Status byte; undefined bits read zero.
  always_comb begin
    status = cslc_pkg::RST_BYTE;
    status[cslc_pkg::STS_EXT_BIT] = stable.ext;
    status[cslc_pkg::STS_XTAL_BIT] = stable.xtal;
    status[cslc_pkg::STS_SLOW_BIT] = stable.slow;
    status[cslc_pkg::STS_FAST_BIT] = stable.fast;
    status[cslc_pkg::STS_SWITCH_BIT] = switching;
  end

  // Read multiplexer; the lock register always reads zero.
  always_comb begin
    rd_byte = cslc_pkg::RST_BYTE;
    if (hit_lock) begin
      rd_byte[cslc_pkg::LOCK_BIT] = 1'b0;
    end
    if (hit_status) begin
      rd_byte = status;
    end
    if (hit_fast) begin
      rd_byte[cslc_pkg::RUN_IN_STANDBY_BIT] = fast_stdby_r;
    end
    if (hit_freq) begin
      rd_byte[cslc_pkg::FREQ_W-1:0] = freq_cal_r;
    end
    if (hit_temp) begin
      rd_byte[cslc_pkg::CAL_LOCK_BIT] = cal_lock_r;
      rd_byte[cslc_pkg::TEMP_W-1:0] = temp_cal_r;
    end
    if (hit_slow) begin
      rd_byte[cslc_pkg::RUN_IN_STANDBY_BIT] = slow_stdby_r;
    end
    if (hit_xtal) begin
      rd_byte[cslc_pkg::XTAL_EN_BIT] = xtal_en_r;
      rd_byte[cslc_pkg::RUN_IN_STANDBY_BIT] = xtal_stdby_r;
      rd_byte[cslc_pkg::XTAL_SEL_BIT] = xtal_sel_r;
      rd_byte[cslc_pkg::CRYSTAL_STARTUP_COUNT_MSB:cslc_pkg::CRYSTAL_STARTUP_COUNT_LSB] = crystal_startup_count_r;
    end
  end

  // Read data registered at the setup cycle so it is stable in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // Outputs toward oscillators, consumers and the main selector.
  assign osc_enable.fast = fast_run;
  assign osc_enable.slow = slow_run;
  assign osc_enable.xtal = xtal_run;
  assign osc_enable.ext = req.ext;
  assign osc_gate = stable;
  assign freq_trim_field = freq_cal_r;
  assign temp_slope_trim = temp_cal_r;
  assign crystal_pin_override = xtal_en_r;
  assign crystal_source_ext = xtal_sel_r;
  assign main_clock_active = active_src_r;
  assign main_ctrl_locked = main_lock_r;

endmodule

// file: tb/cslc_osc_model.sv
// Behavioural oscillators and clock pins that face the clock source block.
`timescale 1ns/100ps
module cslc_osc_model #(
  parameter int FAST_NS = 200, // Fast oscillator analog start-up.
  parameter int SLOW_NS = 400 // Slow oscillator analog start-up.
) (
  input wire cslc_pkg::cslc_src_t osc_enable, // Analog run enables.
  output logic fast_osc_ready = 1'b0, // Fast oscillator ready.
  output logic slow_osc_ready = 1'b0, // Slow oscillator ready.
  output logic crystal_pin_one_clk = 1'b0, // Crystal clock.
  output logic external_clock_input = 1'b0 // External clock pin.
);
  ////////////////////////////////////////////////////////////
  // Ready rises after a start-up delay and falls as soon as the enable drops.
  always begin
    wait (osc_enable.fast);
    #FAST_NS fast_osc_ready = osc_enable.fast;
    wait (!osc_enable.fast);
    fast_osc_ready = 1'b0;
  end
  always begin
    wait (osc_enable.slow);
    #SLOW_NS slow_osc_ready = osc_enable.slow;
    wait (!osc_enable.slow);
    slow_osc_ready = 1'b0;
  end
  // The crystal swings only while enabled and rests low otherwise.
  always #61 crystal_pin_one_clk = osc_enable.xtal ? ~crystal_pin_one_clk : 1'b0;
  always #53 external_clock_input = ~external_clock_input;
endmodule

// file: tb/cslc_top_monitor.sv
// Port checker for the clock source lock and status block.
`timescale 1ns/100ps
module cslc_top_monitor (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic [9:0] paddr, // Address.
  input wire logic pslverr, // Error.
  input wire logic [1:0] main_clock_select, // Requested source.
  input wire cslc_pkg::cslc_src_t periph_req, // Requests.
  input wire cslc_pkg::cslc_src_t osc_enable, // Run enables.
  input wire cslc_pkg::cslc_src_t osc_gate, // Gates.
  input wire logic [6:0] freq_trim_field, // Trim.
  input wire logic crystal_pin_override, // Crystal enable.
  input wire logic crystal_source_ext, // Crystal select.
  input wire logic [1:0] main_clock_active, // Active source.
  input wire logic main_ctrl_locked // Lock.
);
  logic [3:0] gv, rq, gv_r, rq_r;
  ////////////////////////////////////////////////////////////
  // Requests from peripherals, the selector and the running source.
  assign gv = osc_gate;
  assign rq = periph_req | (4'h1 << main_clock_select) | (4'h1 << main_clock_active);
  // Delayed copies for checks that span a cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gv_r <= 4'h0;
      rq_r <= 4'hF;
    end else begin
      gv_r <= gv;
      rq_r <= rq;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  property p_lock; main_ctrl_locked |=> main_ctrl_locked; endproperty
  a_lock: assert property (p_lock) else $error("lock released");
  property p_cal; main_ctrl_locked && main_clock_active == 2'h0 |=> $stable(freq_trim_field); endproperty
  a_cal: assert property (p_cal) else $error("trim changed while locked");
  property p_req; (gv & ~rq & ~rq_r) == 4'h0; endproperty
  a_req: assert property (p_req) else $error("gate open without request");
  property p_dly; $rose(osc_gate.fast) |-> $past(rq[0], 4); endproperty
  a_dly: assert property (p_dly) else $error("gate opened too early");
  property p_sw; $changed(main_clock_active) |-> gv_r[main_clock_active] && main_clock_active == $past(main_clock_select); endproperty
  a_sw: assert property (p_sw) else $error("switch before stable");
  property p_sel; crystal_pin_override && $past(crystal_pin_override) |-> $stable(crystal_source_ext); endproperty
  a_sel: assert property (p_sel) else $error("select changed while enabled");
  property p_xen; osc_enable.xtal |-> crystal_pin_override; endproperty
  a_xen: assert property (p_xen) else $error("crystal runs while disabled");
  property p_err; psel && penable && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned access accepted");
endmodule
bind cslc_top cslc_top_monitor cslc_top_monitor_inst (.pclk, .presetn, .psel, .penable, .paddr,
  .pslverr, .main_clock_select, .periph_req, .osc_enable, .osc_gate, .freq_trim_field,
  .crystal_pin_override, .crystal_source_ext, .main_clock_active, .main_ctrl_locked);

// file: tb/tb_top.sv
// Self-checking bench for the clock source lock and status block.
`timescale 1ns/100ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic protect_open = 1'b0;
  logic fuse_osc_lock_bit = 1'b0;
  logic fuse_freq_select = 1'b1;
  logic [1:0] main_clock_select = 2'h0;
  cslc_pkg::cslc_src_t periph_req = 4'h0;
  cslc_pkg::cslc_src_t osc_enable, osc_gate;
  logic [31:0] prdata;
  logic [6:0] freq_trim_field;
  logic [3:0] temp_slope_trim;
  logic [1:0] main_clock_active;
  logic [7:0] rd;
  logic pready, pslverr, err, fast_osc_ready, slow_osc_ready, crystal_pin_one_clk;
  logic external_clock_input, crystal_pin_override, crystal_source_ext, main_ctrl_locked;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  ////////////////////////////////////////////////////////////
  cslc_top #(.XTAL_SUT_1K(8), .XTAL_SUT_16K(16), .XTAL_SUT_32K(24), .XTAL_SUT_64K(32),
    .FREQ_CAL_20M(7'h2A))
    cslc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .protect_open, .fuse_osc_lock_bit, .fuse_freq_select,
    .main_clock_select, .periph_req, .fast_osc_ready, .slow_osc_ready, .crystal_pin_one_clk,
    .external_clock_input, .osc_enable, .osc_gate, .freq_trim_field, .temp_slope_trim,
    .crystal_pin_override, .crystal_source_ext, .main_clock_active, .main_ctrl_locked);
  cslc_osc_model cslc_osc_model_inst (.osc_enable, .fast_osc_ready, .slow_osc_ready,
    .crystal_pin_one_clk, .external_clock_input);
  // Clock and hang guard.
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus transfer; starts one edge after the caller to leave an idle gap.
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    chk(rd, e);
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    n = 0;
    do begin
      apb(1'b0, 10'h00C, 8'h0);
      n++;
    end while ((rd & m) !== e && n < 400);
    chk(rd & m, e);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    protect_open <= 1'b1;
    rdc(10'h00C, 8'h00);
    rdc(10'h044, 8'h2A);
    rdc(10'h048, 8'h08);
    rdc(10'h070, 8'h00);
    rdc(10'h014, 8'h00);
    chk({7'h0, err}, 8'h01);
    apb(1'b0, 10'h041, 8'h0);
    chk({7'h0, err}, 8'h01);
    poll(8'hFF, 8'h10);
    wr(10'h060, 8'h02);
    #1 chk({7'h0, osc_enable.slow}, 8'h01);
    repeat (20) @(posedge pclk);
    rdc(10'h00C, 8'h10);
    periph_req.slow <= 1'b1;
    poll(8'h20, 8'h20);
    periph_req.slow <= 1'b0;
    poll(8'h20, 8'h00);
    periph_req.ext <= 1'b1;
    poll(8'h80, 8'h80);
    periph_req.ext <= 1'b0;
    poll(8'h80, 8'h00);
    protect_open <= 1'b0;
    wr(10'h040, 8'h02);
    rdc(10'h040, 8'h00);
    protect_open <= 1'b1;
    wr(10'h040, 8'h02);
    rdc(10'h040, 8'h02);
    wr(10'h044, 8'h11);
    rdc(10'h044, 8'h11);
    wr(10'h048, 8'h83);
    rdc(10'h048, 8'h03);
    wr(10'h00C, 8'hFF);
    rdc(10'h00C, 8'h10);
    periph_req.xtal <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(10'h070, 8'h00);
      poll(8'h40, 8'h00);
      wr(10'h070, {2'h0, k[1:0], 4'h0});
      wr(10'h070, {2'h0, k[1:0], 4'h3});
      poll(8'h40, 8'h40);
      chk({7'h0, n >= 8 * (k + 1) && n < 8 * (k + 1) + 12}, 8'h01);
    end
    wr(10'h070, 8'h07);
    rdc(10'h070, 8'h33);
    chk({6'h0, crystal_pin_override, crystal_source_ext}, 8'h02);
    wr(10'h070, 8'h04);
    rdc(10'h070, 8'h30);
    poll(8'h40, 8'h00);
    wr(10'h070, 8'h04);
    #1 chk({7'h0, crystal_source_ext}, 8'h01);
    wr(10'h070, 8'h07);
    poll(8'h40, 8'h40);
    chk({7'h0, n < 12}, 8'h01);
    periph_req.xtal <= 1'b0;
    wr(10'h070, 8'h05);
    #1 chk({7'h0, osc_enable.xtal}, 8'h00);
    @(posedge pclk);
    main_clock_select <= 2'h1;
    rdc(10'h00C, 8'h11);
    poll(8'h01, 8'h00);
    rdc(10'h00C, 8'h20);
    chk({6'h0, main_clock_active}, 8'h01);
    main_clock_select <= 2'h0;
    poll(8'h01, 8'h00);
    wr(10'h008, 8'h01);
    wr(10'h044, 8'h22);
    rdc(10'h044, 8'h11);
    wr(10'h008, 8'h00);
    #1 chk({7'h0, main_ctrl_locked}, 8'h01);
    @(posedge pclk);
    fuse_osc_lock_bit <= 1'b1;
    fuse_freq_select <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk({7'h0, main_ctrl_locked}, 8'h01);
    rdc(10'h044, 8'h40);
    wr(10'h048, 8'h01);
    rdc(10'h048, 8'h88);
    give_verdict();
  end
endmodule
